//--- hw/hbws_dev.sv
// device end: 32/16-bit host port with half word pairing and word swap
//
// Summary of operation
// [R1] strap picks width, shown in config bit 2
// [R2] host writes a dword as two halves
// [R3] host keeps A2 and above across pair
// [R4] either half first, second is the other
// [R5] same half written twice drops the dword
// [R6] host reads a dword as two halves
// [R7] same half read twice: invalid, restart pairing
// [R8] upper data lines never driven in 16-bit
// [R9] 32-bit mode ignores word swap setting
// [R10] default map: select low picks low word
// [R11] swap all ones: select low picks high
// [R12] mapping applies to registers and fifos alike
// [R13] low word moves first, low select first
// [R14] swapped: select high data comes first
// [R15] first write half staged until its partner
`timescale 1ns/1ps
`default_nettype none
module hbws_dev #(
  parameter int ADDR_W = hbws_pkg::ADDR_W
) (
  input  wire logic               mclk_in,
  input  wire logic               nrst_in,
  hbws_if.dev                     bus_if,
  input  wire logic [31:0]        word_swap_in,
  input  wire logic [31:0]        core_rdata_in,
  output logic                    core_wr_out,
  output logic                    core_rd_out,
  output logic [ADDR_W-2:0]       core_addr_out,
  output logic [31:0]             core_wdata_out,
  output logic [31:0]             hardware_config_register_out,
  output logic                    lo_first_a1_out,
  output logic                    wr_discard_out,
  output logic                    rd_invalid_out
);

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  logic             strap_s1_ff;
  logic             strap_s2_ff;
  logic [1:0]       strap_cnt_ff;
  logic             cfg_valid_ff;
  logic             width16_ff;

  // the strap is a board pin, so it passes two flops first
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else begin
      strap_s1_ff <= bus_if.bus_width_strap_pin;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // latched once after release; the width never moves while running
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_cnt_ff <= 2'h0;
      cfg_valid_ff <= 1'b0;
      width16_ff   <= 1'b0;
    end else if (!cfg_valid_ff) begin
      if (strap_cnt_ff == hbws_pkg::STRAP_CAPTURE) begin
        cfg_valid_ff <= 1'b1;
        width16_ff   <= (strap_s2_ff != hbws_pkg::STRAP_32_LVL);   // [R1]
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic             wr_req;
  logic             rd_req;
  logic             swap_on;
  logic             hi_sel;
  logic [ADDR_W-2:0] dw_addr;

  // requests before the strap is taken are ignored
  assign wr_req  = cfg_valid_ff & ~bus_if.cs_n & ~bus_if.wr_n;
  assign rd_req  = cfg_valid_ff & ~bus_if.cs_n & ~bus_if.rd_n & bus_if.wr_n;
  assign swap_on = width16_ff & (word_swap_in == hbws_pkg::SWAP_ALL_ONES);      // [R9] [R11]
  assign hi_sel  = bus_if.addr[0] ^ swap_on;                                    // [R10] [R11] [R12]
  assign dw_addr = bus_if.addr[ADDR_W-1:1];                                     // [R3]

  // places a half word into the low or high word of a dword
  function automatic logic [31:0] hbws_merge(input logic [31:0] word,
                                             input logic [15:0] half,
                                             input logic        hi);
    logic [31:0] res;
    res = word;
    if (hi) begin
      res[31:16] = half;
    end else begin
      res[15:0] = half;
    end
    return res;
  endfunction : hbws_merge

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  logic             wr_pend_ff;
  logic             wr_hi_ff;
  logic [15:0]      wr_stage_ff;
  logic             core_wr_ff;
  logic             wr_discard_ff;
  logic [31:0]      core_wdata_ff;
  logic [ADDR_W-2:0] core_addr_ff;

  // the first half waits in the staging latch so the core only sees whole dwords
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_ff    <= 1'b0;
      wr_hi_ff      <= 1'b0;
      wr_stage_ff   <= hbws_pkg::HALF_RST;
      core_wr_ff    <= 1'b0;
      wr_discard_ff <= 1'b0;
      core_wdata_ff <= hbws_pkg::WORD_RST;
    end else begin
      core_wr_ff    <= 1'b0;
      wr_discard_ff <= 1'b0;
      if (wr_req) begin
        if (!width16_ff) begin
          core_wr_ff    <= 1'b1;
          core_wdata_ff <= bus_if.bus_d;                                       // [R9]
        end else if (!wr_pend_ff) begin
          wr_pend_ff  <= 1'b1;                                                 // [R15]
          wr_hi_ff    <= hi_sel;
          wr_stage_ff <= bus_if.bus_d[15:0];
        end else if (hi_sel != wr_hi_ff) begin
          wr_pend_ff    <= 1'b0;                                               // [R4]
          core_wr_ff    <= 1'b1;                                               // [R15]
          core_wdata_ff <= hbws_merge(hbws_merge(hbws_pkg::WORD_RST, wr_stage_ff, wr_hi_ff),
                                      bus_if.bus_d[15:0], hi_sel);
        end else begin
          wr_pend_ff    <= 1'b0;                                               // [R5]
          wr_discard_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path, first stage: fetch from the core or from the held dword
  // ----------------------------------------------------------------------
  logic             rd_pend_ff;
  logic             rd_hi_ff;
  logic             rd_go_ff;
  logic             rd_core_ff;
  logic             rd_full_ff;
  logic             rd_out_hi_ff;
  logic             core_rd_ff;
  logic             rd_invalid_ff;

  // only the first half of a pair pops the core, so a fifo advances once per dword
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_pend_ff    <= 1'b0;
      rd_hi_ff      <= 1'b0;
      rd_go_ff      <= 1'b0;
      rd_core_ff    <= 1'b0;
      rd_full_ff    <= 1'b0;
      rd_out_hi_ff  <= 1'b0;
      core_rd_ff    <= 1'b0;
      rd_invalid_ff <= 1'b0;
    end else begin
      rd_go_ff      <= rd_req;
      core_rd_ff    <= 1'b0;
      rd_core_ff    <= 1'b0;
      rd_invalid_ff <= 1'b0;
      if (rd_req) begin
        rd_full_ff   <= ~width16_ff;
        rd_out_hi_ff <= hi_sel;                                                // [R12]
        if (!width16_ff) begin
          core_rd_ff <= 1'b1;
          rd_core_ff <= 1'b1;
        end else if (!rd_pend_ff) begin
          core_rd_ff <= 1'b1;                                                  // [R6]
          rd_core_ff <= 1'b1;
          rd_pend_ff <= 1'b1;
          rd_hi_ff   <= hi_sel;
        end else if (hi_sel != rd_hi_ff) begin
          rd_pend_ff <= 1'b0;                                                  // [R4]
        end else begin
          rd_pend_ff    <= 1'b0;                                               // [R7]
          rd_invalid_ff <= 1'b1;
        end
      end
    end
  end

  // core address follows the last pin request, even a half that never reaches the core
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_addr_ff <= '0;
    end else if (wr_req | rd_req) begin
      core_addr_ff <= dw_addr;
    end
  end

  // ----------------------------------------------------------------------
  // read path, second stage: drive the pins for one cycle
  // ----------------------------------------------------------------------
  logic [31:0]      rd_buf_ff;
  logic [31:0]      dev_d_ff;
  logic             oe_lo_ff;
  logic             oe_hi_ff;
  logic [31:0]      rd_word;

  assign rd_word = rd_core_ff ? core_rdata_in : rd_buf_ff;

  // upper lanes only ever drive in the 32-bit mode
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_buf_ff <= hbws_pkg::WORD_RST;
      dev_d_ff  <= hbws_pkg::WORD_RST;
      oe_lo_ff  <= 1'b0;
      oe_hi_ff  <= 1'b0;
    end else begin
      oe_lo_ff <= rd_go_ff;
      oe_hi_ff <= rd_go_ff & rd_full_ff;                                       // [R8]
      if (rd_core_ff) begin
        rd_buf_ff <= core_rdata_in;
      end
      if (rd_go_ff) begin
        if (rd_full_ff) begin
          dev_d_ff <= rd_word;                                                 // [R9]
        end else begin
          dev_d_ff <= {16'h0000, rd_out_hi_ff ? rd_word[31:16] : rd_word[15:0]}; // [R10] [R11]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // status toward the rest of the device
  // ----------------------------------------------------------------------
  logic [31:0]      hardware_config_register_ff;
  logic             lo_first_ff;

  // the low word always meets the network first, so the select level that
  // carries it tells software which half of fifo data leads
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hardware_config_register_ff   <= hbws_pkg::HARDWARE_CONFIG_REGISTER_RST;
      lo_first_ff <= 1'b0;
    end else begin
      hardware_config_register_ff   <= hbws_pkg::HARDWARE_CONFIG_REGISTER_RST;
      hardware_config_register_ff[hbws_pkg::CFG_WIDTH_BIT] <= ~width16_ff;                       // [R1]
      lo_first_ff <= swap_on;                                                  // [R13] [R14]
    end
  end

  assign bus_if.dev_d     = dev_d_ff;
  assign bus_if.dev_oe_lo = oe_lo_ff;
  assign bus_if.dev_oe_hi = oe_hi_ff;
  assign core_wr_out      = core_wr_ff;
  assign core_rd_out      = core_rd_ff;
  assign core_addr_out    = core_addr_ff;
  assign core_wdata_out   = core_wdata_ff;
  assign hardware_config_register_out       = hardware_config_register_ff;
  assign lo_first_a1_out  = lo_first_ff;
  assign wr_discard_out   = wr_discard_ff;
  assign rd_invalid_out   = rd_invalid_ff;

endmodule : hbws_dev
`default_nettype wire

//--- hw/hbws_host.sv
// host end: splits dword requests into pin cycles of the chosen width
`timescale 1ns/1ps
`default_nettype none
module hbws_host #(
  parameter int ADDR_W = hbws_pkg::ADDR_W
) (
  input  wire logic               mclk_in,
  input  wire logic               nrst_in,
  hbws_if.host                    bus_if,
  input  wire logic               strap_32_in,
  input  wire logic [31:0]        word_swap_in,
  input  wire logic               req_in,
  input  wire logic               we_in,
  input  wire logic [ADDR_W-2:0]  addr_in,
  input  wire logic [31:0]        wdata_in,
  input  wire logic               lo_first_in,
  output logic                    busy_out,
  output logic                    done_out,
  output logic [31:0]             rdata_out
);

  // ----------------------------------------------------------------------
  // request latch and sequencer
  // ----------------------------------------------------------------------
  hbws_pkg::hbws_hstate_t state_ff;
  logic             strap_ff;
  logic             we_ff;
  logic             lo_first_ff;
  logic             swap_ff;
  logic             w16_ff;
  logic             step_ff;
  logic [ADDR_W-2:0] addr_ff;
  logic [31:0]      wdata_ff;
  logic [31:0]      rdata_ff;
  logic             busy_ff;
  logic             done_ff;
  logic             cs_n_ff;
  logic             rd_n_ff;
  logic             wr_n_ff;
  logic [ADDR_W-1:0] pin_addr_ff;
  logic [31:0]      host_d_ff;
  logic             oe_lo_ff;
  logic             oe_hi_ff;
  logic             log_hi;

  // low half goes first when asked, the pair always covers both halves
  assign log_hi = lo_first_ff ? step_ff : ~step_ff;                            // [R4]

  // left unreset so the pin already shows the board level at release
  always_ff @(posedge mclk_in) begin
    strap_ff <= strap_32_in;
  end

  // one pin cycle is strobe, wait, sample; a 16-bit dword runs it twice
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff    <= hbws_pkg::HBWS_IDLE;
      we_ff       <= 1'b0;
      lo_first_ff <= 1'b1;
      swap_ff     <= 1'b0;
      w16_ff      <= 1'b0;
      step_ff     <= 1'b0;
      addr_ff     <= '0;
      wdata_ff    <= hbws_pkg::WORD_RST;
      rdata_ff    <= hbws_pkg::WORD_RST;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      cs_n_ff     <= 1'b1;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
      pin_addr_ff <= '0;
      host_d_ff   <= hbws_pkg::WORD_RST;
      oe_lo_ff    <= 1'b0;
      oe_hi_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        hbws_pkg::HBWS_IDLE: begin
          if (req_in) begin
            we_ff       <= we_in;
            addr_ff     <= addr_in;
            wdata_ff    <= wdata_in;
            lo_first_ff <= lo_first_in;
            w16_ff      <= (strap_32_in != hbws_pkg::STRAP_32_LVL);
            swap_ff     <= (strap_32_in != hbws_pkg::STRAP_32_LVL) &
                           (word_swap_in == hbws_pkg::SWAP_ALL_ONES);
            step_ff     <= 1'b0;
            busy_ff     <= 1'b1;
            state_ff    <= hbws_pkg::HBWS_LOAD;
          end
        end
        hbws_pkg::HBWS_LOAD: begin
          cs_n_ff     <= 1'b0;
          rd_n_ff     <= we_ff;
          wr_n_ff     <= ~we_ff;
          pin_addr_ff <= {addr_ff, log_hi ^ swap_ff};                          // [R3]
          oe_lo_ff    <= we_ff;
          oe_hi_ff    <= we_ff & ~w16_ff;
          host_d_ff   <= w16_ff ? {16'h0000, log_hi ? wdata_ff[31:16] : wdata_ff[15:0]} : wdata_ff; // [R2]
          state_ff    <= hbws_pkg::HBWS_STROBE;
        end
        hbws_pkg::HBWS_STROBE: begin
          cs_n_ff  <= 1'b1;
          rd_n_ff  <= 1'b1;
          wr_n_ff  <= 1'b1;
          oe_lo_ff <= 1'b0;
          oe_hi_ff <= 1'b0;
          state_ff <= hbws_pkg::HBWS_WAIT;
        end
        hbws_pkg::HBWS_WAIT: begin
          state_ff <= hbws_pkg::HBWS_SAMPLE;
        end
        hbws_pkg::HBWS_SAMPLE: begin
          if (!we_ff) begin
            if (!w16_ff) begin
              rdata_ff <= bus_if.bus_d;
            end else if (log_hi) begin
              rdata_ff[31:16] <= bus_if.bus_d[15:0];                           // [R6]
            end else begin
              rdata_ff[15:0] <= bus_if.bus_d[15:0];
            end
          end
          if (w16_ff && !step_ff) begin
            step_ff  <= 1'b1;
            state_ff <= hbws_pkg::HBWS_LOAD;
          end else begin
            busy_ff  <= 1'b0;
            done_ff  <= 1'b1;
            state_ff <= hbws_pkg::HBWS_IDLE;
          end
        end
        default: begin
          state_ff <= hbws_pkg::HBWS_IDLE;
        end
      endcase
    end
  end

  assign bus_if.cs_n                = cs_n_ff;
  assign bus_if.rd_n                = rd_n_ff;
  assign bus_if.wr_n                = wr_n_ff;
  assign bus_if.addr                = pin_addr_ff;
  assign bus_if.bus_width_strap_pin = strap_ff;
  assign bus_if.host_d              = host_d_ff;
  assign bus_if.host_oe_lo          = oe_lo_ff;
  assign bus_if.host_oe_hi          = oe_hi_ff;
  assign busy_out                   = busy_ff;
  assign done_out                   = done_ff;
  assign rdata_out                  = rdata_ff;

endmodule : hbws_host
`default_nettype wire

//--- pkg/hbws_if.sv
// pin level carrier between the embedded host and the adapter
`timescale 1ns/1ps
`default_nettype none
interface hbws_if;

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  logic                         cs_n;
  logic                         rd_n;
  logic                         wr_n;
  logic [hbws_pkg::ADDR_W-1:0]  addr;       // bit 0 is the half word select address
  logic                         bus_width_strap_pin;
  logic [hbws_pkg::DATA_W-1:0]  host_d;
  logic                         host_oe_lo;
  logic                         host_oe_hi;
  logic [hbws_pkg::DATA_W-1:0]  dev_d;
  logic                         dev_oe_lo;
  logic                         dev_oe_hi;
  logic [hbws_pkg::DATA_W-1:0]  bus_d;      // resolved level of the data wires

  // undriven lanes fall to zero, standing in for the internal pull-downs
  assign bus_d[15:0]  = host_oe_lo ? host_d[15:0]  : (dev_oe_lo ? dev_d[15:0]  : 16'h0000);
  assign bus_d[31:16] = host_oe_hi ? host_d[31:16] : (dev_oe_hi ? dev_d[31:16] : 16'h0000);

  modport dev (
    input  cs_n, rd_n, wr_n, addr, bus_width_strap_pin, bus_d,
    output dev_d, dev_oe_lo, dev_oe_hi
  );

  modport host (
    output cs_n, rd_n, wr_n, addr, bus_width_strap_pin, host_d, host_oe_lo, host_oe_hi,
    input  bus_d
  );

endinterface : hbws_if
`default_nettype wire

//--- pkg/hbws_pkg.sv
// shared constants and types of the host bus width and word swap adapter
package hbws_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 8;   // address pins, bit 0 is the half word select
  localparam int          DATA_W       = 32;
  localparam int          HALF_W       = 16;

  // ----------------------------------------------------------------------
  // configuration fields and reset values
  // ----------------------------------------------------------------------
  localparam int          CFG_WIDTH_BIT = 2;              // width flag in the hardware config word
  localparam logic        STRAP_32_LVL  = 1'b1;           // strap level that picks the 32-bit bus
  localparam logic [31:0] SWAP_ALL_ONES = 32'hffffffff;   // only this value turns word swap on
  localparam logic [31:0] HARDWARE_CONFIG_REGISTER_RST    = 32'h00000000;
  localparam logic [31:0] WORD_RST      = 32'h00000000;
  localparam logic [15:0] HALF_RST      = 16'h0000;
  localparam logic [1:0]  STRAP_CAPTURE = 2'h2;           // edges after release before the strap is taken

  // ----------------------------------------------------------------------
  // host sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HBWS_IDLE   = 3'b000,
    HBWS_LOAD   = 3'b001,
    HBWS_STROBE = 3'b010,
    HBWS_WAIT   = 3'b011,
    HBWS_SAMPLE = 3'b100
  } hbws_hstate_t;

endpackage : hbws_pkg

//--- sim/hbws_pins_sva.sv
// checker for the pin bus that joins the host end to the device end
`timescale 1ns/1ps
`default_nettype none
module hbws_pins_sva (
  input wire logic                        mclk_in,
  input wire logic                        nrst_in,
  input wire logic                        cs_n,
  input wire logic                        rd_n,
  input wire logic                        wr_n,
  input wire logic [hbws_pkg::ADDR_W-1:0] addr,
  input wire logic                        bus_width_strap_pin,
  input wire logic                        host_oe_lo,
  input wire logic                        host_oe_hi,
  input wire logic                        dev_oe_lo,
  input wire logic                        dev_oe_hi
);
  // ------------------------------
  // helpers
  // ------------------------------
  localparam int AW = hbws_pkg::ADDR_W;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  wire logic          rd_stb = !cs_n && !rd_n && wr_n;
  wire logic          wr_stb = !cs_n && !wr_n;
  wire logic          w16    = !bus_width_strap_pin;
  logic               wr_odd_ff;
  logic               rd_odd_ff;
  logic [AW-1:0]      wr_a_ff;
  logic [AW-1:0]      rd_a_ff;
  // pair phase in 16-bit mode; one lost half would shift every later pair
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_odd_ff <= 1'b0;
      rd_odd_ff <= 1'b0;
      wr_a_ff   <= '0;
      rd_a_ff   <= '0;
    end else begin
      if (wr_stb && w16) begin
        wr_odd_ff <= !wr_odd_ff;
        wr_a_ff   <= addr;
      end
      if (rd_stb && w16) begin
        rd_odd_ff <= !rd_odd_ff;
        rd_a_ff   <= addr;
      end
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  sequence s_rd_req;
    rd_stb;
  endsequence
  sequence s_rd_ans;
    ##2 dev_oe_lo;
  endsequence
  AST_RD_LAT: assert property (s_rd_req |-> s_rd_ans) else $error("read data late");
  AST_RD_FULL: assert property (bus_width_strap_pin && rd_stb |-> ##2 dev_oe_hi) else $error("upper lane idle");
  AST_HI_OFF: assert property (w16 |-> !dev_oe_hi) else $error("upper lane driven in 16-bit");
  AST_OE_ONE: assert property (dev_oe_lo |=> !dev_oe_lo) else $error("read data held too long");
  AST_OE_CAUSE: assert property ($rose(dev_oe_lo) |-> $past(rd_stb, 2)) else $error("drive without read");
  AST_NO_CLASH: assert property (!(host_oe_lo && dev_oe_lo)) else $error("both ends drive low lane");
  AST_HOST_HI: assert property (w16 |-> !host_oe_hi) else $error("host drives upper lane");
  AST_WR_PAIR: assert property (wr_stb && w16 && wr_odd_ff |-> (addr ^ wr_a_ff) == AW'(1))
    else $error("bad write pair");
  AST_RD_PAIR: assert property (rd_stb && w16 && rd_odd_ff |-> (addr ^ rd_a_ff) == AW'(1))
    else $error("bad read pair");
endmodule : hbws_pins_sva
`default_nettype wire

//--- sim/host_bus_width_word_swap_bench.sv
// bench: host and device ends joined, plus a second device fed broken pairs
`timescale 1ns/1ps
`default_nettype none
module host_bus_width_word_swap_bench;
  // ------------------------------
  // stimulus and observed values
  // ------------------------------
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        strap   = 1'b1;
  logic [31:0] swap    = 32'h00000000;
  logic        req     = 1'b0;
  logic        we      = 1'b0;
  logic [6:0]  a7      = 7'h00;
  logic [31:0] wd      = 32'h00000000;
  logic        lof     = 1'b0;
  logic [31:0] crd     = 32'h00000000;
  logic        busy, done, cwr, crp, lo_a1, wr2, rd2, dis2, inv2, wa0;
  logic [31:0] rdata, cwd, cfg, cw_seen;
  logic [6:0]  ca, ca_seen;
  logic [15:0] wdl;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          n_wr2 = 0, n_rd2 = 0, n_dis = 0, n_inv = 0, n_pop = 0;
  hbws_if ifa();
  hbws_if ifb();
  hbws_host hbws_host_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus_if(ifa.host), .strap_32_in(strap),
    .word_swap_in(swap), .req_in(req), .we_in(we), .addr_in(a7), .wdata_in(wd), .lo_first_in(lof),
    .busy_out(busy), .done_out(done), .rdata_out(rdata));
  hbws_dev hbws_dev_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus_if(ifa.dev), .word_swap_in(swap),
    .core_rdata_in(crd), .core_wr_out(cwr), .core_rd_out(crp), .core_addr_out(ca), .core_wdata_out(cwd),
    .hardware_config_register_out(cfg), .lo_first_a1_out(lo_a1), .wr_discard_out(), .rd_invalid_out());
  hbws_dev hbws_dev_f_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus_if(ifb.dev), .word_swap_in(swap),
    .core_rdata_in(crd), .core_wr_out(wr2), .core_rd_out(rd2), .core_addr_out(), .core_wdata_out(),
    .hardware_config_register_out(), .lo_first_a1_out(), .wr_discard_out(dis2), .rd_invalid_out(inv2));
  hbws_pins_sva hbws_pins_sva_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .cs_n(ifa.cs_n), .rd_n(ifa.rd_n),
    .wr_n(ifa.wr_n), .addr(ifa.addr), .bus_width_strap_pin(ifa.bus_width_strap_pin),
    .host_oe_lo(ifa.host_oe_lo), .host_oe_hi(ifa.host_oe_hi), .dev_oe_lo(ifa.dev_oe_lo), .dev_oe_hi(ifa.dev_oe_hi));
  // ------------------------------
  // clock and monitors
  // ------------------------------
  always #25 mclk_in = ~mclk_in;
  // core hand-offs and the last write half seen on the wire
  always @(posedge mclk_in) begin
    if (cwr) {cw_seen, ca_seen} = {cwd, ca};
    if (!ifa.cs_n && !ifa.wr_n) {wa0, wdl} = {ifa.addr[0], ifa.bus_d[15:0]};
    if (crp) n_pop++;
    if (wr2) n_wr2++;
    if (rd2) n_rd2++;
    if (dis2) n_dis++;
    if (inv2) n_inv++;
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // the strap is only taken after a release, so a width change needs a reset
  task automatic do_reset(input logic s);
    @(negedge mclk_in);
    nrst_in = 1'b0;
    strap = s;
    repeat (10) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (6) @(negedge mclk_in);
  endtask : do_reset
  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
    int k;
    @(negedge mclk_in);
    req = 1'b1;
    we = w;
    a7 = a;
    wd = d;
    @(negedge mclk_in);
    req = 1'b0;
    chk("busy_out", 32'h1, {31'h0, busy});
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(negedge mclk_in);
      k++;
    end
    chk("done_out", 32'h1, {31'h0, done});
  endtask : xfer
  // one raw strobe on the second bus, spaced five cycles
  task automatic pin(input logic w, input logic a0, input logic [15:0] d);
    @(negedge mclk_in);
    {ifb.cs_n, ifb.wr_n, ifb.rd_n} = {1'b0, ~w, w};
    ifb.addr = {7'h2a, a0};
    ifb.host_d = {16'h0000, d};
    ifb.host_oe_lo = w;
    @(negedge mclk_in);
    {ifb.cs_n, ifb.wr_n, ifb.rd_n} = 3'h7;
    ifb.host_oe_lo = 1'b0;
    ifb.host_d = ~ifb.host_d;
    repeat (3) @(negedge mclk_in);
  endtask : pin
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_w32;
    do_reset(1'b1);
    swap = 32'hffffffff;
    chk("cfg width", 32'h1, {31'h0, cfg[hbws_pkg::CFG_WIDTH_BIT]});
    xfer(1'b1, 7'h15, 32'hc3a55a3c);
    chk("core wdata", 32'hc3a55a3c, cw_seen);
    chk("core addr", 32'h15, {25'h0, ca_seen});
    crd = 32'h9b7e1d24;
    xfer(1'b0, 7'h15, 32'h00000000);
    chk("rdata", 32'h9b7e1d24, rdata);
    $display("test width32 done");
  endtask : t_w32
  task automatic t_w16;
    logic [31:0] sws [3];
    logic [31:0] d;
    logic        sw;
    sws = '{32'h00000000, 32'hfffffffe, 32'hffffffff};
    do_reset(1'b0);
    chk("cfg width", 32'h0, {31'h0, cfg[hbws_pkg::CFG_WIDTH_BIT]});
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        swap = sws[i];
        sw = (sws[i] == 32'hffffffff);
        lof = j[0];
        d = {16'h8100 + 16'(i * 2 + j), 16'h2400 + 16'(i * 2 + j)};
        xfer(1'b1, 7'h40 + 7'(i * 2 + j), d);
        chk("core wdata", d, cw_seen);
        chk("last a1", {31'h0, lof ^ sw}, {31'h0, wa0});
        chk("last half", {16'h0, lof ? d[31:16] : d[15:0]}, {16'h0, wdl});
        crd = ~d;
        xfer(1'b0, 7'h40 + 7'(i * 2 + j), 32'h00000000);
        chk("rdata", ~d, rdata);
        chk("first a1", {31'h0, sw}, {31'h0, lo_a1});
      end
    end
    chk("core pops", 32'h7, n_pop);
    $display("test width16 done");
  endtask : t_w16
  task automatic t_fault;
    pin(1'b1, 1'b0, 16'h1111);
    pin(1'b1, 1'b0, 16'h2222);
    chk("discards", 32'h1, n_dis);
    chk("commits", 32'h0, n_wr2);
    pin(1'b1, 1'b1, 16'h3333);
    pin(1'b1, 1'b0, 16'h4444);
    chk("commits", 32'h1, n_wr2);
    pin(1'b0, 1'b0, 16'h0000);
    pin(1'b0, 1'b0, 16'h0000);
    chk("invalid", 32'h1, n_inv);
    chk("pops", 32'h1, n_rd2);
    pin(1'b0, 1'b1, 16'h0000);
    chk("pops", 32'h2, n_rd2);
    pin(1'b0, 1'b0, 16'h0000);
    chk("pops", 32'h2, n_rd2);
    $display("test broken pairs done");
  endtask : t_fault
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ------------------------------
  // main sequence and watchdog
  // ------------------------------
  initial begin
    {ifb.cs_n, ifb.rd_n, ifb.wr_n} = 3'h7;
    ifb.addr = 8'h00;
    ifb.host_d = 32'h00000000;
    {ifb.host_oe_lo, ifb.host_oe_hi, ifb.bus_width_strap_pin} = 3'h0;
    t_w32();
    t_w16();
    t_fault();
    tally_and_finish();
  end
  // the tests need well under 2000 cycles; 20000 means a hang
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : host_bus_width_word_swap_bench
`default_nettype wire
